//--- design/prt_translator.sv
// Protected region translator: access check, translation and trap sequencing
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module prt_translator
   import prt_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic [prt_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_write,
   input wire logic i_reg_read,
   output logic [31:0] o_reg_rdata,
   input wire logic i_acc_valid,
   input wire logic [31:0] i_acc_addr,
   input wire prt_pkg::prt_kind_type i_acc_kind,
   input wire logic [31:0] i_acc_wdata,
   output logic o_acc_ready,
   output logic o_mem_valid,
   output logic [31:0] o_mem_addr,
   output prt_pkg::prt_kind_type o_mem_kind,
   output logic [31:0] o_mem_wdata,
   input wire logic i_workspace_update,
   input wire logic [31:0] i_workspace_pointer,
   input wire logic i_priv_instr,
   input wire logic i_error,
   input wire logic i_syscall,
   output logic o_protected,
   output logic o_state_valid,
   output logic [prt_pkg::STATE_AW-1:0] o_state_index,
   output logic [31:0] o_state_data,
   output logic o_process_start,
   output logic [prt_pkg::STATE_AW-1:0] o_save_index,
   input wire logic [31:0] i_save_data,
   output logic o_supervisor_restart
);
   import prt_pkg::*;

   prt_state_type state_reg;
   prt_state_type state_next;
   prt_cause_type cause_reg;
   prt_cause_type trap_cause;
   logic [3:0][31:0] stage_reg;
   logic [3:0][31:0] active_reg;
   logic [15:0] tslice_reg;
   logic [15:0] slice_cnt_reg;
   logic [6:0] tick_cnt_reg;
   logic tick;
   logic [31:0] trap_addr_reg;
   logic [STATE_AW:0] seq_cnt_reg;
   logic rd_mem_reg;
   logic [31:0] rdata_reg;
   logic acc_legal;
   logic [31:0] acc_phys;
   logic workspace_legal;
   logic trap;
   logic enter;
   logic status_clear;
   logic reg_hit_state;
   logic [STATE_AW-1:0] mem_addr;
   logic mem_we;
   logic [31:0] mem_wdata;
   logic [31:0] mem_rdata;

   prt_region_if rif ();
   assign rif.desc = active_reg;

   prt_region_check u_acc_check (
      .rif(rif),
      .i_addr(i_acc_addr),
      .i_kind(i_acc_kind),
      .o_legal(acc_legal),
      .o_phys(acc_phys)
   );

   // The workspace must stay writable, so it is checked as a write
   prt_region_check u_workspace_check (
      .rif(rif),
      .i_addr(i_workspace_pointer),
      .i_kind(PRT_ACC_WRITE),
      .o_legal(workspace_legal),
      .o_phys()
   );

   prt_state_mem u_state_mem (
      .i_clock(i_clock),
      .i_rstn(i_rstn),
      .i_addr(mem_addr),
      .i_we(mem_we),
      .i_wdata(mem_wdata),
      .o_rdata(mem_rdata)
   );

   assign reg_hit_state = i_reg_addr >= OFS_STATE &&
      i_reg_addr < OFS_STATE + 8'(4 * STATE_WORDS);
   assign enter = i_reg_write && i_reg_addr == OFS_CTRL &&
      i_reg_wdata[CTRL_ENTER_BIT] && state_reg == PRT_IDLE;
   assign status_clear = i_reg_write && i_reg_addr == OFS_STATUS;

   // Highest priority first; only one cause is kept per trap
   always_comb
   begin
      trap_cause = PRT_CAUSE_NONE;
      if (i_acc_valid && !acc_legal)
         trap_cause = PRT_CAUSE_ACCESS; // [RL4] [RL9]
      else if (i_workspace_update && !workspace_legal)
         trap_cause = PRT_CAUSE_WORKSPACE; // [RL10]
      else if (i_priv_instr)
         trap_cause = PRT_CAUSE_PRIV; // [RL4]
      else if (i_error)
         trap_cause = PRT_CAUSE_ERROR; // [RL4]
      else if (slice_cnt_reg >= tslice_reg)
         trap_cause = PRT_CAUSE_TSLICE; // [RL5]
      else if (i_syscall)
         trap_cause = PRT_CAUSE_SYSCALL; // [RL5]
   end

   assign trap = state_reg == PRT_RUN && trap_cause != PRT_CAUSE_NONE;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         PRT_IDLE:
            if (enter)
               state_next = PRT_LOAD; // [RL2]
         PRT_LOAD:
            if (seq_cnt_reg == (STATE_AW+1)'(STATE_WORDS))
               state_next = PRT_RUN;
         PRT_RUN:
            if (trap)
               state_next = PRT_SAVE; // [RL6]
         PRT_SAVE:
            if (seq_cnt_reg == (STATE_AW+1)'(STATE_WORDS - 1))
               state_next = PRT_RESTART; // [RL6]
         PRT_RESTART:
            state_next = PRT_IDLE;
         default:
            state_next = PRT_IDLE;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         state_reg <= PRT_IDLE;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         seq_cnt_reg <= '0;
      else if (state_reg != state_next)
         seq_cnt_reg <= '0;
      else if (state_reg == PRT_LOAD || state_reg == PRT_SAVE)
         seq_cnt_reg <= seq_cnt_reg + (STATE_AW+1)'(1);
   end

   // Memory port: sequencer owns it outside idle, software inside
   always_comb
   begin
      mem_addr = seq_cnt_reg[STATE_AW-1:0];
      mem_we = 1'b0;
      mem_wdata = i_save_data;
      if (state_reg == PRT_SAVE)
         mem_we = 1'b1; // [RL6]
      else if (state_reg == PRT_IDLE)
      begin
         mem_addr = i_reg_addr[STATE_AW+1:2];
         mem_we = i_reg_write && reg_hit_state;
         mem_wdata = i_reg_wdata;
      end
   end

   assign o_save_index = seq_cnt_reg[STATE_AW-1:0];
   assign o_state_data = mem_rdata;

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_state_valid <= 1'b0;
         o_state_index <= '0;
      end
      else
      begin
         o_state_valid <= state_reg == PRT_LOAD &&
            seq_cnt_reg < (STATE_AW+1)'(STATE_WORDS); // [RL2]
         o_state_index <= seq_cnt_reg[STATE_AW-1:0];
      end
   end

   assign o_process_start = state_reg == PRT_LOAD && state_next == PRT_RUN;
   assign o_supervisor_restart = state_reg == PRT_RESTART;
   assign o_protected = state_reg == PRT_RUN;

   // Regions staged by software are taken only at entry
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         active_reg <= {4{REGION_RESET}};
      else if (enter)
         active_reg <= stage_reg; // [RL2] [RL7]
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         stage_reg <= {4{REGION_RESET}};
         tslice_reg <= TSLICE_RESET;
      end
      else if (i_reg_write)
      begin
         for (int r = 0; r < 4; r++)
            if (i_reg_addr == OFS_REGION + 8'(4 * r))
               stage_reg[r] <= i_reg_wdata;
         if (i_reg_addr == OFS_TSLICE)
            tslice_reg <= i_reg_wdata[15:0];
      end
   end

   // Timeslice counted in microsecond ticks
   assign tick = tick_cnt_reg == 7'(TICK_CYCLES - 1);

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         tick_cnt_reg <= '0;
      else if (tick || state_reg != PRT_RUN)
         tick_cnt_reg <= '0;
      else
         tick_cnt_reg <= tick_cnt_reg + 7'h01;
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         slice_cnt_reg <= '0;
      else if (enter)
         slice_cnt_reg <= '0;
      else if (tick && slice_cnt_reg != 16'hffff)
         slice_cnt_reg <= slice_cnt_reg + 16'h0001; // [RL5]
   end

   // A trap in the same cycle as a clear keeps its cause
   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cause_reg <= PRT_CAUSE_NONE;
         trap_addr_reg <= 32'h0000_0000;
      end
      else if (trap)
      begin
         cause_reg <= trap_cause; // [RL21]
         trap_addr_reg <= trap_cause == PRT_CAUSE_WORKSPACE ?
            i_workspace_pointer : i_acc_addr;
      end
      else if (status_clear || enter)
         cause_reg <= PRT_CAUSE_NONE;
   end

   // Ordinary processes pass untouched; protected ones are taken at once and checked in the same cycle
   assign o_acc_ready = state_reg == PRT_IDLE || state_reg == PRT_RUN;

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_mem_valid <= 1'b0;
         o_mem_addr <= 32'h0000_0000;
         o_mem_kind <= PRT_ACC_READ;
         o_mem_wdata <= 32'h0000_0000;
      end
      else
      begin
         o_mem_valid <= 1'b0;
         if (state_reg == PRT_IDLE && i_acc_valid)
         begin
            o_mem_valid <= 1'b1; // [RL1]
            o_mem_addr <= i_acc_addr;
         end
         else if (state_reg == PRT_RUN && i_acc_valid && !trap)
         begin
            o_mem_valid <= 1'b1; // [RL20]
            o_mem_addr <= acc_phys; // [RL3]
         end
         o_mem_kind <= i_acc_kind;
         o_mem_wdata <= i_acc_wdata;
      end
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         rdata_reg <= 32'h0000_0000;
         rd_mem_reg <= 1'b0;
      end
      else
      begin
         rd_mem_reg <= i_reg_read && reg_hit_state && state_reg == PRT_IDLE;
         rdata_reg <= 32'h0000_0000;
         if (i_reg_read)
         begin
            case (i_reg_addr)
               OFS_STATUS:
               begin
                  rdata_reg[ST_STATE_LSB +: 3] <= state_reg;
                  rdata_reg[ST_RUN_BIT] <= state_reg == PRT_RUN;
                  rdata_reg[ST_CAUSE_LSB +: 3] <= cause_reg;
                  rdata_reg[ST_RESTART_OK_BIT] <=
                     cause_reg == PRT_CAUSE_WORKSPACE; // [RL10]
               end
               OFS_TSLICE: rdata_reg <= {16'h0000, tslice_reg};
               OFS_TRAP_ADDR: rdata_reg <= trap_addr_reg;
               default:
                  for (int r = 0; r < 4; r++)
                     if (i_reg_addr == OFS_REGION + 8'(4 * r))
                        rdata_reg <= stage_reg[r];
            endcase
         end
      end
   end

   assign o_reg_rdata = rd_mem_reg ? mem_rdata : rdata_reg;
endmodule

//--- design/prt_pkg.sv
// Constants, types and the translate function for the region translator
// Contract
// [RL1] Checking and translation act only while a protected process runs.
// [RL2] Enter command loads process state, the four regions, then runs it.
// [RL3] Every protected access is logical, checked, then translated.
// [RL4] Illegal address, privileged instruction or error traps to supervisor.
// [RL5] Timeslice expiry or system call also traps to the supervisor.
// [RL6] On a trap the process state is saved, then supervisor restarts.
// [RL7] Four regions, each with independent size, permissions and translation.
// [RL8] Reads anywhere; writes need write permit, fetches need execute permit.
// [RL9] Every read, write and fetch is checked; illegal ones trap.
// [RL10] Call or adjust leaving workspace unwritable traps; restart allowed.
// [RL11] Region sizes are powers of two from 256 bytes to 2^30 bytes.
// [RL12] A region relocates onto any physical boundary of its own size.
// [RL13] Supervisor keeps the physical ranges of the regions disjoint.
// [RL14] Legal addresses are the top or bottom 2^n of the region.
// [RL15] Zero and the null pointer can be made illegal and then trap.
// [RL16] Top two logical address bits select region zero to three.
// [RL17] Descriptor bit 0 write, bit 1 execute, bit 2 top placement.
// [RL18] Bit n-1 marks size; bits 31 to n replace logical bits.
// [RL19] Logical bits n to 29 all ones for top, zeros for bottom.
// [RL20] Check completes before issue; no illegal access reaches memory.
// [RL21] Trap cause is recorded for the supervisor to inspect.
package prt_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_TSLICE = 8'h08;
   localparam logic [7:0] OFS_TRAP_ADDR = 8'h0c;
   localparam logic [7:0] OFS_REGION = 8'h10;
   localparam logic [7:0] OFS_STATE = 8'h40;
   localparam int CTRL_ENTER_BIT = 0;
   localparam int ST_STATE_LSB = 0;
   localparam int ST_RUN_BIT = 3;
   localparam int ST_CAUSE_LSB = 4;
   localparam int ST_RESTART_OK_BIT = 7;
   localparam int DESC_WRITE_BIT = 0;
   localparam int DESC_EXEC_BIT = 1;
   localparam int DESC_TOP_BIT = 2;
   localparam int MIN_SIZE_LOG2 = 8;
   localparam int MAX_SIZE_LOG2 = 30;
   localparam logic [31:0] NULL_DESC = 32'h0800_0000;
   localparam logic [31:0] REGION_RESET = 32'h0800_0000;
   localparam int STATE_WORDS = 8;
   localparam int STATE_AW = 3;
   localparam logic [15:0] TSLICE_RESET = 16'h03e8;
   localparam int CLOCK_NS = 8;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYCLES = TICK_NS / CLOCK_NS;

   typedef enum logic [1:0] {
      PRT_ACC_READ = 2'h0,
      PRT_ACC_WRITE = 2'h1,
      PRT_ACC_FETCH = 2'h2
   } prt_kind_type;

   typedef enum logic [2:0] {
      PRT_CAUSE_NONE = 3'h0,
      PRT_CAUSE_ACCESS = 3'h1,
      PRT_CAUSE_WORKSPACE = 3'h2,
      PRT_CAUSE_PRIV = 3'h3,
      PRT_CAUSE_ERROR = 3'h4,
      PRT_CAUSE_TSLICE = 3'h5,
      PRT_CAUSE_SYSCALL = 3'h6
   } prt_cause_type;

   typedef enum logic [2:0] {
      PRT_IDLE = 3'h0,
      PRT_LOAD = 3'h1,
      PRT_RUN = 3'h3,
      PRT_SAVE = 3'h2,
      PRT_RESTART = 3'h6
   } prt_state_type;

   // Returns {legal, physical}; an unusable descriptor gives no legal address
   function automatic logic [32:0] prt_translate(input logic [31:0] desc,
                                                 input logic [31:0] addr);
      logic found;
      logic ok;
      logic [31:0] low;
      logic [29:0] mid;
      logic [31:0] phys;
      found = 1'b0;
      ok = 1'b0;
      phys = 32'h0000_0000;
      for (int k = MIN_SIZE_LOG2; k <= MAX_SIZE_LOG2; k++)
      begin
         if (!found && desc[k-1]) // [RL11] [RL18]
         begin
            found = 1'b1;
            low = ~(32'hffff_ffff << k);
            mid = 30'h3fff_ffff & ~low[29:0];
            if (desc[DESC_TOP_BIT]) // [RL14] [RL19]
               ok = (addr[29:0] & mid) == mid;
            else
               ok = (addr[29:0] & mid) == 30'h0000_0000;
            phys = (desc & ~low) | (addr & low); // [RL12] [RL18]
         end
      end
      ok = ok && found && desc[6:3] == 4'h0 && desc != NULL_DESC;
      return {ok, phys};
   endfunction
endpackage

//--- design/prt_region_if.sv
// Carries the four active region descriptors to the checkers
`timescale 1ns/10ps
interface prt_region_if;
   logic [3:0][31:0] desc;
   modport src (output desc);
   modport chk (input desc);
endinterface

//--- design/prt_region_check.sv
// Checks one logical access against the regions and translates it
`timescale 1ns/10ps
module prt_region_check
   import prt_pkg::*;
(
   prt_region_if.chk rif,
   input wire logic [31:0] i_addr,
   input wire prt_pkg::prt_kind_type i_kind,
   output logic o_legal,
   output logic [31:0] o_phys
);
   logic [31:0] desc;
   logic [32:0] res;
   logic permit;

   assign desc = rif.desc[i_addr[31:30]]; // [RL16] [RL7]
   assign res = prt_translate(desc, i_addr); // [RL3]

   always_comb
   begin
      case (i_kind) // [RL8]
         PRT_ACC_READ: permit = 1'b1;
         PRT_ACC_WRITE: permit = desc[DESC_WRITE_BIT]; // [RL17]
         PRT_ACC_FETCH: permit = desc[DESC_EXEC_BIT]; // [RL17]
         default: permit = 1'b0;
      endcase
   end

   // Zero and null pointer fail here unless a region covers them
   assign o_legal = res[32] && permit; // [RL15] [RL9]
   assign o_phys = res[31:0];
endmodule

//--- design/prt_state_mem.sv
// Small single-port memory holding the saved protected process state
`timescale 1ns/10ps
module prt_state_mem
   import prt_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic [prt_pkg::STATE_AW-1:0] i_addr,
   input wire logic i_we,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [STATE_WORDS];

   always_ff @(posedge i_clock)
   begin
      if (i_we)
         mem[i_addr] <= i_wdata;
   end

   always_ff @(posedge i_clock or negedge i_rstn)
   begin
      if (!i_rstn)
         o_rdata <= 32'h0000_0000;
      else
         o_rdata <= mem[i_addr];
   end
endmodule

//--- testbench/prt_core_model.sv
// Core-side model presenting state words during the save sweep
`timescale 1ns/10ps
module prt_core_model
   import prt_pkg::*;
#(
   parameter logic [31:0] SAVE_BASE = 32'h5a5a_0000
)
(
   input wire logic i_saving,
   input wire logic [prt_pkg::STATE_AW-1:0] i_save_index,
   output logic [31:0] o_save_data
);
   logic [31:0] word;
   assign word = SAVE_BASE | 32'(i_save_index);
   // Junk outside a save, so a stale word cannot pass by luck
   assign o_save_data = i_saving ? word : ~word;
endmodule

//--- testbench/prt_translator_chk.sv
// Port-level assertions for the region translator
`timescale 1ns/10ps
module prt_translator_chk
   import prt_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rstn,
   input wire logic i_acc_valid,
   input wire logic [31:0] i_acc_addr,
   input wire logic i_priv_instr,
   input wire logic i_error,
   input wire logic i_syscall,
   input wire logic o_acc_ready,
   input wire logic o_mem_valid,
   input wire logic [31:0] o_mem_addr,
   input wire logic o_protected,
   input wire logic o_state_valid,
   input wire logic [prt_pkg::STATE_AW-1:0] o_state_index,
   input wire logic o_process_start,
   input wire logic [prt_pkg::STATE_AW-1:0] o_save_index,
   input wire logic o_supervisor_restart
);
   logic took;
   logic sync;
   assign took = i_acc_valid && o_acc_ready;
   assign sync = i_priv_instr || i_error || i_syscall;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rstn);
   property p_bypass;
      !o_protected && took |=> o_mem_valid && o_mem_addr == $past(i_acc_addr);
   endproperty
   property p_issue;
      o_mem_valid |-> $past(took);
   endproperty
   property p_checked;
      o_protected && i_acc_valid |=> o_mem_valid || !o_protected;
   endproperty
   property p_sync;
      o_protected && sync |=> !o_protected;
   endproperty
   property p_save;
      $fell(o_protected) |-> !o_supervisor_restart [*8] ##1
         o_supervisor_restart;
   endproperty
   property p_save_idx;
      $fell(o_protected) |-> o_save_index == 3'h0 ##7 o_save_index == 3'h7;
   endproperty
   property p_load;
      $rose(o_state_valid) |-> o_state_index == 3'h0 ##7 o_process_start;
   endproperty
   property p_start;
      o_process_start |-> o_state_valid && o_state_index == 3'h7 ##1
         o_protected;
   endproperty
   property p_restart;
      o_supervisor_restart |=> o_acc_ready && !o_protected;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("unprotected access not passed through");
   a_issue: assert property (p_issue)
      else $error("memory access without a request");
   a_checked: assert property (p_checked)
      else $error("protected access neither issued nor trapped");
   a_sync: assert property (p_sync)
      else $error("core event did not trap");
   a_save: assert property (p_save)
      else $error("restart not after eight save cycles");
   a_save_idx: assert property (p_save_idx)
      else $error("save index sweep wrong");
   a_load: assert property (p_load)
      else $error("state load sweep wrong");
   a_start: assert property (p_start)
      else $error("process start not followed by run");
   a_restart: assert property (p_restart)
      else $error("restart not back to idle");
   c_start: cover property (o_process_start);
   c_trap: cover property ($fell(o_protected));
   c_issue: cover property (o_protected && o_mem_valid);
endmodule

//--- testbench/prt_translator_test.sv
// Self-checking bench for the protected region translator
`timescale 1ns/10ps
module prt_translator_test;
   import prt_pkg::*;
   logic i_clock = 1'b0;
   logic i_rstn = 1'b0;
   logic [7:0] i_reg_addr = 8'h00;
   logic [31:0] i_reg_wdata = 32'h0;
   logic i_reg_write = 1'b0;
   logic i_reg_read = 1'b0;
   logic i_acc_valid = 1'b0;
   logic [31:0] i_acc_addr = 32'h0;
   prt_kind_type i_acc_kind = PRT_ACC_READ;
   logic [31:0] i_acc_wdata = 32'h0;
   logic i_workspace_update = 1'b0;
   logic [31:0] i_workspace_pointer = 32'h0;
   logic i_priv_instr = 1'b0, i_error = 1'b0, i_syscall = 1'b0;
   logic [31:0] i_save_data, o_reg_rdata, o_mem_addr, o_mem_wdata;
   logic [31:0] o_state_data;
   logic o_acc_ready, o_mem_valid, o_protected, o_state_valid;
   logic o_process_start, o_supervisor_restart;
   prt_kind_type o_mem_kind;
   logic [STATE_AW-1:0] o_state_index, o_save_index;
   logic [31:0] seed = 32'h8297;
   logic [31:0] st [8];
   logic [65:0] mq [$];
   logic [34:0] sq [$];
   logic [31:0] rq [$];
   logic rd_d = 1'b0;
   int fail_count = 0;
   int checks_done = 0;

   prt_translator dut (.*);
   prt_core_model core (
      .i_saving(!o_acc_ready),
      .i_save_index(o_save_index),
      .o_save_data(i_save_data)
   );

   always #4 i_clock = ~i_clock;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(string n, logic [65:0] s, logic [65:0] e);
      checks_done++;
      if (s !== e)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Samples on the falling edge so design updates have landed
   task automatic wait_hi(logic w, int lim);
      int n;
      for (n = 0; n < lim; n++)
      begin
         @(negedge i_clock);
         if ((w ? o_supervisor_restart : o_protected) === 1'b1)
            break;
      end
      @(posedge i_clock);
      if (n == lim)
      begin
         fail_count++;
         report_and_stop();
      end
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_write <= 1'b1;
      @(posedge i_clock);
      i_reg_write <= 1'b0;
      @(posedge i_clock);
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] e);
      rq.push_back(e);
      i_reg_addr <= a;
      i_reg_read <= 1'b1;
      @(posedge i_clock);
      i_reg_read <= 1'b0;
      @(posedge i_clock);
   endtask

   // Leaves the request up; caller drops valid after the last one
   task automatic acc(logic [31:0] a, prt_kind_type k, logic [31:0] p);
      logic [31:0] d;
      d = rnd();
      mq.push_back({k, p, d});
      i_acc_valid <= 1'b1;
      i_acc_addr <= a;
      i_acc_kind <= k;
      i_acc_wdata <= d;
      @(posedge i_clock);
   endtask

   task automatic enter();
      for (int i = 0; i < 8; i++)
         sq.push_back({3'(i), st[i]});
      wr(OFS_CTRL, 32'h1);
      wait_hi(1'b0, 30);
   endtask

   task automatic trap(int k, logic [2:0] c, logic [31:0] a);
      if (o_protected !== 1'b1)
         enter();
      i_acc_valid <= k < 3;
      i_acc_kind <= prt_kind_type'(k == 0 ? 2'h1 : k == 1 ? 2'h2 : 2'h0);
      i_acc_addr <= a;
      i_workspace_update <= k == 3;
      i_workspace_pointer <= a;
      i_priv_instr <= k == 4;
      i_error <= k == 5;
      i_syscall <= k == 6;
      @(posedge i_clock);
      i_acc_valid <= 1'b0;
      i_workspace_update <= 1'b0;
      i_priv_instr <= 1'b0;
      i_error <= 1'b0;
      i_syscall <= 1'b0;
      wait_hi(1'b1, 300);
      rd(OFS_STATUS, {c == 3'h2, c, 4'h0});
      if (c < 3'h3)
         rd(OFS_TRAP_ADDR, a);
      rd(OFS_STATE + 8'h14, 32'h5a5a_0005);
      for (int i = 0; i < 8; i++)
         st[i] = 32'h5a5a_0000 | i;
      $display("trap test %0d done", k);
   endtask

   always @(posedge i_clock)
   begin
      if (rd_d)
         chk("rdata", o_reg_rdata, rq.pop_front());
      if (o_state_valid === 1'b1)
         chk("state", {o_state_index, o_state_data}, sq.pop_front());
      if (o_mem_valid === 1'b1)
         chk("mem", {o_mem_kind, o_mem_addr, o_mem_wdata},
            mq.size() ? mq.pop_front() : '1);
      rd_d <= i_reg_read;
   end

   initial
   begin
      logic [31:0] a;
      @(negedge i_clock);
      chk("ready", o_acc_ready, 1'b1);
      chk("prot", o_protected, 1'b0);
      repeat (3) @(posedge i_clock);
      i_rstn <= 1'b1;
      rd(OFS_STATUS, 32'h0);
      rd(OFS_TSLICE, 32'(TSLICE_RESET));
      rd(OFS_REGION, REGION_RESET);
      rd(8'h80, 32'h0);
      a = rnd();
      acc(a, PRT_ACC_WRITE, a);
      acc(~a, PRT_ACC_FETCH, ~a);
      i_acc_valid <= 1'b0;
      $display("bypass test done");
      wr(OFS_REGION, 32'h1234_5687);
      wr(OFS_REGION + 8'h4, 32'h0abc_c800);
      wr(OFS_REGION + 8'h8, NULL_DESC);
      wr(OFS_REGION + 8'hc, 32'h6000_0003);
      for (int i = 0; i < 8; i++)
      begin
         st[i] = rnd();
         wr(OFS_STATE + 8'(4 * i), st[i]);
      end
      enter();
      rd(OFS_STATUS, 32'h0000_000b);
      a = rnd();
      acc(32'h3fff_ff00 | a[7:0], PRT_ACC_READ,
         32'h1234_5600 | a[7:0]);
      acc(32'h3fff_ff00 | a[15:8], PRT_ACC_WRITE,
         32'h1234_5600 | a[15:8]);
      acc(32'h3fff_ffff, PRT_ACC_FETCH, 32'h1234_56ff);
      acc(32'h4000_0000 | a[11:0], PRT_ACC_READ,
         32'h0abc_c000 | a[11:0]);
      acc({2'h3, a[29:0]}, PRT_ACC_WRITE, {2'h1, a[29:0]});
      i_acc_valid <= 1'b0;
      i_workspace_update <= 1'b1;
      i_workspace_pointer <= 32'h3fff_ff40;
      @(posedge i_clock);
      i_workspace_update <= 1'b0;
      rd(OFS_STATUS, 32'h0000_000b);
      $display("translate test done");
      trap(0, 3'h1, 32'h4000_0010);
      trap(1, 3'h1, 32'h4000_0010);
      trap(2, 3'h1, 32'h0000_0000);
      trap(2, 3'h1, 32'h8000_0000);
      trap(2, 3'h1, 32'h4000_1000);
      trap(3, 3'h2, 32'h4000_0020);
      trap(4, 3'h3, 32'h0);
      trap(5, 3'h4, 32'h0);
      trap(6, 3'h6, 32'h0);
      // Any value written to status clears the recorded cause
      wr(OFS_STATUS, rnd());
      rd(OFS_STATUS, 32'h0);
      $display("status clear test done");
      wr(OFS_TSLICE, 32'h1);
      trap(7, 3'h5, 32'h0);
      acc(a, PRT_ACC_READ, a);
      i_acc_valid <= 1'b0;
      repeat (2) @(posedge i_clock);
      chk("pending", mq.size(), 0);
      report_and_stop();
   end
endmodule

bind prt_translator prt_translator_chk chk (.*);
